// [shared/e3oh_map.vh]
// register map, field positions and reset values for the e3 overhead byte block
`ifndef E3OH_MAP_VH
`define E3OH_MAP_VH

// register indices; byte address is four times the index
`define E3OH_IDX_RX_OPERATOR 8'h1a
`define E3OH_IDX_RX_CHANNEL 8'h1b
`define E3OH_IDX_TX_CHANNEL 8'h35
`define E3OH_IDX_TX_OPERATOR 8'h37
`define E3OH_IDX_CTRL 8'h38
`define E3OH_IDX_STATUS 8'h39

// control register fields
`define E3OH_CTRL_LINK_LSB 0
`define E3OH_CTRL_LINK_MSB 1
`define E3OH_CTRL_PT_LSB 2
`define E3OH_CTRL_PT_MSB 4
`define E3OH_CTRL_TM_BIT 5

// message link carrier select
`define E3OH_LINK_NONE 2'h0
`define E3OH_LINK_OPERATOR 2'h1
`define E3OH_LINK_CHANNEL 2'h2

// payload type codes
`define E3OH_PT_UNEQUIPPED 3'h0
`define E3OH_PT_EQUIPPED 3'h1
`define E3OH_PT_CELLS 3'h2
`define E3OH_PT_TRIBUTARY 3'h3

// maintenance byte field positions
`define E3OH_MA_FERF_BIT 7
`define E3OH_MA_FEBE_BIT 6
`define E3OH_MA_PT_MSB 5
`define E3OH_MA_PT_LSB 3
`define E3OH_MA_TM_BIT 0

// status register fields
`define E3OH_STAT_FERF_BIT 0
`define E3OH_STAT_FEBE_BIT 1
`define E3OH_STAT_OVF_BIT 2
`define E3OH_STAT_TXHOLD_BIT 3

// reset values
`define E3OH_RST_CTRL 8'h04
`define E3OH_RST_TX_BYTE 8'h00
`define E3OH_RST_RX_BYTE 8'h00

// idle octet sent on the message link when no octet is waiting
`define E3OH_LINK_IDLE 8'h7e

`endif

// [rtl/e3oh_buf2.v]
// two-entry buffer with valid/ready on both sides, outputs straight from flip-flops
`timescale 1ns/10ps
`default_nettype none
module e3oh_buf2 (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // fill side
  input wire in_valid,
  input wire [7:0] in_data,
  output wire in_ready,
  // drain side
  output wire out_valid,
  output wire [7:0] out_data,
  input wire out_ready
);
  reg [7:0] mem [0:1];
  reg valid0;
  reg valid1;
  wire push;
  wire pop;
  assign in_ready = ~valid1;
  assign out_valid = valid0;
  assign out_data = mem[0];
  assign push = in_valid & ~valid1;
  assign pop = valid0 & out_ready;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      valid0 <= 1'b0;
      valid1 <= 1'b0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (pop) begin
        mem[0] <= valid1 ? mem[1] : in_data;
        valid0 <= valid1 | push;
        valid1 <= 1'b0;
        if (valid1 && push) begin
          mem[1] <= in_data;
          valid1 <= 1'b1;
        end
      end else if (push) begin
        if (valid0) begin
          mem[1] <= in_data;
          valid1 <= 1'b1;
        end else begin
          mem[0] <= in_data;
          valid0 <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/e3oh_overhead.v]
// maintenance, operator and channel overhead byte handling for the e3 framer
// Functional notes
// - any receive los, oof or ais sets the far-end failure bit seven outbound
// - failure bit stays set in every frame while the receive problem persists
// - no receive problem sends the failure bit as zero
// - error-monitor mismatch sets the block error bit six in an outbound frame
// - no mismatch sends the block error bit as zero
// - frame judged by own parity against error-monitor byte of next frame
// - bits five to three carry the software selected payload type code
// - bit zero is zero when timing is traceable to primary reference
// - operator or channel byte selectable to carry one link octet per frame
// - operator byte not on link carries transmit operator register value
// - each received operator byte captured into readable receive register
// - channel byte not on link carries transmit channel register value
// - each received channel byte captured into readable receive register
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "e3oh_map.vh"
module e3oh_overhead (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // receive framer status
  input wire rx_los,
  input wire rx_oof,
  input wire rx_ais,
  input wire rx_frame_end,
  input wire [7:0] rx_bip_calc,
  // receive overhead bytes, valid for one cycle per frame
  input wire rx_ovh_valid,
  input wire [7:0] rx_em_byte,
  input wire [7:0] rx_ma_byte,
  input wire [7:0] rx_nr_byte,
  input wire [7:0] rx_gc_byte,
  // transmit overhead request and bytes
  input wire tx_ovh_req,
  output reg tx_ovh_valid,
  output reg [7:0] tx_ma_byte,
  output reg [7:0] tx_nr_byte,
  output reg [7:0] tx_gc_byte,
  // transmit message link octets
  input wire msg_tx_valid,
  input wire [7:0] msg_tx_data,
  output reg msg_tx_ready,
  // receive message link octets
  output wire msg_rx_valid,
  output wire [7:0] msg_rx_data,
  input wire msg_rx_ready,
  // received maintenance byte fields
  output reg rx_far_fail,
  output reg rx_far_err
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // assemble the outbound maintenance byte
  function [7:0] ma_pack;
    input ferf;
    input febe;
    input [2:0] ptype;
    input tmark;
    begin
      ma_pack = 8'h00;
      ma_pack[`E3OH_MA_FERF_BIT] = ferf;
      ma_pack[`E3OH_MA_FEBE_BIT] = febe;
      ma_pack[`E3OH_MA_PT_MSB:`E3OH_MA_PT_LSB] = ptype;
      ma_pack[`E3OH_MA_TM_BIT] = tmark;
    end
  endfunction

  // byte-lane merge of a write into an 8-bit register
  function [7:0] lane_write;
    input [7:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    begin
      lane_write = sel[0] ? wdat[7:0] : old;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] rx_operator_byte;
  reg [7:0] rx_channel_byte;
  reg [7:0] tx_channel_byte;
  reg [7:0] tx_operator_byte;
  reg [7:0] ctrl;
  reg rx_ovf;
  reg [7:0] bip_prev;
  reg bip_prev_ok;
  reg febe_pend;
  reg [7:0] tx_hold;
  reg tx_hold_valid;

  wire [1:0] link_sel;
  wire [2:0] ptype;
  wire tmark;
  wire rx_problem;
  wire bus_req;
  wire bus_wr;
  wire [7:0] reg_idx;
  wire tx_take;
  wire tx_use;
  wire [7:0] link_octet;
  wire em_mismatch;
  wire buf_in_valid;
  wire [7:0] buf_in_data;
  wire buf_in_ready;
  wire ovf_clear;

  assign link_sel = ctrl[`E3OH_CTRL_LINK_MSB:`E3OH_CTRL_LINK_LSB];
  assign ptype = ctrl[`E3OH_CTRL_PT_MSB:`E3OH_CTRL_PT_LSB];
  assign tmark = ctrl[`E3OH_CTRL_TM_BIT];
  assign rx_problem = rx_los | rx_oof | rx_ais;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign reg_idx = wb_adr_i[9:2];

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads return zero

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        case (reg_idx)
          `E3OH_IDX_RX_OPERATOR: wb_dat_o[7:0] <= rx_operator_byte;
          `E3OH_IDX_RX_CHANNEL: wb_dat_o[7:0] <= rx_channel_byte;
          `E3OH_IDX_TX_CHANNEL: wb_dat_o[7:0] <= tx_channel_byte;
          `E3OH_IDX_TX_OPERATOR: wb_dat_o[7:0] <= tx_operator_byte;
          `E3OH_IDX_CTRL: wb_dat_o[7:0] <= ctrl;
          `E3OH_IDX_STATUS: begin
            wb_dat_o[`E3OH_STAT_FERF_BIT] <= rx_problem;
            wb_dat_o[`E3OH_STAT_FEBE_BIT] <= febe_pend;
            wb_dat_o[`E3OH_STAT_OVF_BIT] <= rx_ovf;
            wb_dat_o[`E3OH_STAT_TXHOLD_BIT] <= tx_hold_valid;
          end
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // software register writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_channel_byte <= `E3OH_RST_TX_BYTE;
      tx_operator_byte <= `E3OH_RST_TX_BYTE;
      ctrl <= `E3OH_RST_CTRL;
    end else if (bus_wr) begin
      case (reg_idx)
        `E3OH_IDX_TX_CHANNEL: tx_channel_byte <= lane_write(tx_channel_byte, wb_dat_i, wb_sel_i);
        `E3OH_IDX_TX_OPERATOR: tx_operator_byte <= lane_write(tx_operator_byte, wb_dat_i, wb_sel_i);
        `E3OH_IDX_CTRL: ctrl <= lane_write(ctrl, wb_dat_i, wb_sel_i) & 8'h3f;
        default: ctrl <= ctrl;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive side: parity check and byte capture

  // compare last frame's own parity with this frame's monitor byte
  assign em_mismatch = rx_ovh_valid & bip_prev_ok & (rx_em_byte != bip_prev);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bip_prev <= 8'h00;
      bip_prev_ok <= 1'b0;
    end else if (rx_oof || rx_los) begin
      bip_prev_ok <= 1'b0;
    end else if (rx_frame_end) begin
      bip_prev <= rx_bip_calc;
      bip_prev_ok <= 1'b1;
    end
  end

  // capture of received operator and channel bytes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_operator_byte <= `E3OH_RST_RX_BYTE;
      rx_channel_byte <= `E3OH_RST_RX_BYTE;
      rx_far_fail <= 1'b0;
      rx_far_err <= 1'b0;
    end else if (rx_ovh_valid) begin
      rx_operator_byte <= rx_nr_byte;
      rx_channel_byte <= rx_gc_byte;
      // far end decides persistence; only the raw bits are passed on
      rx_far_fail <= rx_ma_byte[`E3OH_MA_FERF_BIT];
      rx_far_err <= rx_ma_byte[`E3OH_MA_FEBE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive message link octets into the two-entry buffer

  assign buf_in_valid = rx_ovh_valid & (link_sel != `E3OH_LINK_NONE);
  assign buf_in_data = (link_sel == `E3OH_LINK_CHANNEL) ? rx_gc_byte : rx_nr_byte;
  assign ovf_clear = bus_wr & (reg_idx == `E3OH_IDX_STATUS) & wb_sel_i[0] & wb_dat_i[`E3OH_STAT_OVF_BIT];

  e3oh_buf2 u_rx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(buf_in_valid),
    .in_data(buf_in_data),
    .in_ready(buf_in_ready),
    .out_valid(msg_rx_valid),
    .out_data(msg_rx_data),
    .out_ready(msg_rx_ready)
  );

  // sticky overflow when an octet arrives with the buffer full; set beats clear
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ovf <= 1'b0;
    end else if (buf_in_valid && !buf_in_ready) begin
      rx_ovf <= 1'b1;
    end else if (ovf_clear) begin
      rx_ovf <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // far-end block error pending flag

  // one mismatch marks one outbound frame; a mismatch at a request edge goes out in that frame
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      febe_pend <= 1'b0;
    end else if (tx_ovh_req) begin
      febe_pend <= 1'b0;
    end else if (em_mismatch) begin
      febe_pend <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit message octet hold register

  assign tx_use = tx_ovh_req & (link_sel != `E3OH_LINK_NONE);
  assign tx_take = msg_tx_valid & msg_tx_ready;
  assign link_octet = tx_hold_valid ? tx_hold : `E3OH_LINK_IDLE;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_hold <= 8'h00;
      tx_hold_valid <= 1'b0;
      msg_tx_ready <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_hold <= msg_tx_data;
        tx_hold_valid <= 1'b1;
      end else if (tx_use) begin
        tx_hold_valid <= 1'b0;
      end
      msg_tx_ready <= ~tx_hold_valid & ~tx_take & (link_sel != `E3OH_LINK_NONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outbound overhead bytes

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ovh_valid <= 1'b0;
      tx_ma_byte <= 8'h00;
      tx_nr_byte <= 8'h00;
      tx_gc_byte <= 8'h00;
    end else begin
      tx_ovh_valid <= tx_ovh_req;
      if (tx_ovh_req) begin
        // failure bit follows the live receive state each frame
        // payload type dependent bits zero timing marker
        tx_ma_byte <= ma_pack(rx_problem, febe_pend | em_mismatch, ptype, tmark);
        if (link_sel == `E3OH_LINK_OPERATOR) begin
          tx_nr_byte <= link_octet;
        end else begin
          tx_nr_byte <= tx_operator_byte;
        end
        if (link_sel == `E3OH_LINK_CHANNEL) begin
          tx_gc_byte <= link_octet;
        end else begin
          tx_gc_byte <= tx_channel_byte;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [verif/e3oh_monitor.sv]
// assertion checker for the e3 overhead byte block
`timescale 1ns/10ps
`default_nettype none
module e3oh_monitor (
  // clock, reset and bus
  input wire sys_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  // overhead and link
  input wire rx_los,
  input wire rx_oof,
  input wire rx_ais,
  input wire rx_ovh_valid,
  input wire [7:0] rx_ma_byte,
  input wire tx_ovh_req,
  input wire tx_ovh_valid,
  input wire [7:0] tx_ma_byte,
  input wire msg_tx_valid,
  input wire msg_tx_ready,
  input wire rx_far_fail,
  input wire rx_far_err
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire bad = rx_los | rx_oof | rx_ais;
  wire [1:0] ma_top = rx_ma_byte[7:6];
  reg seen;
  // a received frame since the last outbound request
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      seen <= 1'h0;
    else
      seen <= (rx_ovh_valid | seen) & !tx_ovh_req;
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  a_ovh_answer: assert property (tx_ovh_req |=> tx_ovh_valid) else $error("no overhead answer");
  a_ferf_set: assert property (tx_ovh_req && bad |=> tx_ma_byte[7]) else $error("failure bit low");
  a_ferf_clear: assert property (tx_ovh_req && !bad |=> !tx_ma_byte[7]) else $error("failure bit high");
  a_febe_quiet: assert property (tx_ovh_req && !seen && !rx_ovh_valid |=> !tx_ma_byte[6]) else $error("febe");
  a_pd_zero: assert property (tx_ovh_valid |-> tx_ma_byte[2:1] == 2'h0) else $error("dependent bits set");
  a_ma_hold: assert property (!tx_ovh_req |=> $stable(tx_ma_byte)) else $error("maintenance byte moved");
  a_far_bits: assert property (rx_ovh_valid |=> {rx_far_fail, rx_far_err} == $past(ma_top)) else $error("far bits");
  a_link_take: assert property (msg_tx_valid && msg_tx_ready |=> !msg_tx_ready) else $error("ready held");
  c_ferf: cover property (tx_ovh_req && bad);
  c_febe: cover property (tx_ovh_valid && tx_ma_byte[6]);
  c_link: cover property (msg_tx_valid && msg_tx_ready);
endmodule
bind e3oh_overhead e3oh_monitor e3oh_monitor_i (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .rx_los, .rx_oof, .rx_ais, .rx_ovh_valid, .rx_ma_byte, .tx_ovh_req, .tx_ovh_valid, .tx_ma_byte,
  .msg_tx_valid, .msg_tx_ready, .rx_far_fail, .rx_far_err);
`default_nettype wire

// [verif/e3oh_far_end.sv]
// remote terminal model: judges outbound failure bit, drains link octets
`timescale 1ns/10ps
`default_nettype none
module e3oh_far_end #(parameter FAIL_N = 3) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tx_ovh_valid,
  input wire logic [7:0] tx_ma_byte,
  input wire logic stall,
  output logic msg_rx_ready,
  output logic far_fail
);
  integer run;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run <= 0;
      far_fail <= 1'h0;
      msg_rx_ready <= 1'h0;
    end else begin
      msg_rx_ready <= !stall;
      if (tx_ovh_valid) begin
        run <= tx_ma_byte[7] ? run + 1 : 0;
        far_fail <= tx_ma_byte[7] && (run + 1 >= FAIL_N);
      end
    end
  end
endmodule
`default_nettype wire

// [verif/test_e3oh_overhead.sv]
// self-checking bench for the e3 overhead byte block
`timescale 1ns/10ps
`default_nettype none
`include "e3oh_map.vh"
module test_e3oh_overhead;
  logic sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_los, rx_oof, rx_ais, rx_frame_end;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic rx_ovh_valid, tx_ovh_req, tx_ovh_valid, msg_tx_valid, msg_tx_ready, msg_rx_valid, msg_rx_ready;
  logic [7:0] rx_bip_calc, rx_em_byte, rx_ma_byte, rx_nr_byte, rx_gc_byte, q, opv, chv;
  logic [7:0] tx_ma_byte, tx_nr_byte, tx_gc_byte, msg_tx_data, msg_rx_data;
  logic rx_far_fail, rx_far_err, stall, far_fail;
  logic [15:0] seed;
  integer failures = 0, n_compared = 0, cyc_n = 0, k;
  int exq[$];
  e3oh_overhead e3oh_overhead_i (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_los, .rx_oof, .rx_ais, .rx_frame_end, .rx_bip_calc, .rx_ovh_valid,
    .rx_em_byte, .rx_ma_byte, .rx_nr_byte, .rx_gc_byte, .tx_ovh_req, .tx_ovh_valid, .tx_ma_byte, .tx_nr_byte,
    .tx_gc_byte, .msg_tx_valid, .msg_tx_data, .msg_tx_ready, .msg_rx_valid, .msg_rx_data, .msg_rx_ready,
    .rx_far_fail, .rx_far_err);
  e3oh_far_end e3oh_far_end_i (.sys_clk, .resetn, .tx_ovh_valid, .tx_ma_byte, .stall, .msg_rx_ready, .far_fail);
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      failures++;
    end
  endtask
  task test_done;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wb(input w, input [7:0] i, input [7:0] v);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= {i, 2'h0};
    wb_dat_i <= {24'h0, v};
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task rdc(input [7:0] i, input [7:0] e);
    wb(1'h0, i, 8'h0);
    chk(q, e);
  endtask
  task txr;
    @(posedge sys_clk);
    tx_ovh_req <= 1'h1;
    @(posedge sys_clk);
    tx_ovh_req <= 1'h0;
    @(posedge sys_clk);
    chk(tx_ovh_valid, 1);
  endtask
  task rxf(input [7:0] b, e, m, n, g);
    @(posedge sys_clk);
    {rx_frame_end, rx_bip_calc} <= {1'h1, b};
    @(posedge sys_clk);
    {rx_frame_end, rx_ovh_valid} <= 2'h1;
    {rx_em_byte, rx_ma_byte, rx_nr_byte, rx_gc_byte} <= {e, m, n, g};
    @(posedge sys_clk);
    rx_ovh_valid <= 1'h0;
  endtask
  task push(input [7:0] v);
    @(posedge sys_clk);
    {msg_tx_valid, msg_tx_data} <= {1'h1, v};
    do begin
      @(posedge sys_clk);
    end while (msg_tx_ready !== 1'h1);
    msg_tx_valid <= 1'h0;
  endtask
  always @(posedge sys_clk) begin
    if (msg_rx_valid === 1'h1 && msg_rx_ready === 1'h1)
      chk(msg_rx_data, exq.size() ? exq.pop_front() : 256);
    cyc_n++;
    if (cyc_n == 5000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_los, rx_oof, rx_ais, rx_frame_end, rx_ovh_valid, tx_ovh_req} = '0;
    {wb_adr_i, wb_dat_i, rx_bip_calc, rx_em_byte, rx_ma_byte, rx_nr_byte, rx_gc_byte, msg_tx_data} = '0;
    {msg_tx_valid, wb_sel_i, stall, resetn, seed} = {1'h0, 4'h1, 2'h0, 16'h7b1d};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'h1;
    rdc(`E3OH_IDX_RX_OPERATOR, 8'h0);
    rdc(`E3OH_IDX_RX_CHANNEL, 8'h0);
    rdc(`E3OH_IDX_CTRL, `E3OH_RST_CTRL);
    seed = lfsr(seed);
    {opv, chv} = seed;
    wb(1'h1, `E3OH_IDX_TX_OPERATOR, opv);
    wb(1'h1, `E3OH_IDX_TX_CHANNEL, chv);
    wb(1'h1, `E3OH_IDX_RX_OPERATOR, 8'hff);
    rdc(`E3OH_IDX_TX_OPERATOR, opv);
    rdc(`E3OH_IDX_TX_CHANNEL, chv);
    rdc(`E3OH_IDX_RX_OPERATOR, 8'h0);
    rdc(8'h00, 8'h0);
    txr;
    chk({tx_ma_byte, tx_nr_byte, tx_gc_byte}, {8'h08, opv, chv});
    $display("test registers done");
    for (k = 0; k < 3; k++) begin
      {rx_los, rx_oof, rx_ais} <= 3'h1 << k;
      txr;
      chk(tx_ma_byte[7], 1);
      txr;
      chk(tx_ma_byte[7], 1);
    end
    chk(far_fail, 1);
    {rx_los, rx_oof, rx_ais} <= 3'h0;
    txr;
    chk(tx_ma_byte, 8'h08);
    repeat (2) @(posedge sys_clk);
    chk(far_fail, 0);
    $display("test failure bit done");
    for (k = 0; k < 8; k++) begin
      wb(1'h1, `E3OH_IDX_CTRL, {2'h0, k[0], 1'h0, k[2:1], 2'h0});
      txr;
      chk(tx_ma_byte, {3'h0, k[2:1], 2'h0, k[0]});
    end
    $display("test payload type done");
    seed = lfsr(seed);
    rxf(seed[7:0], seed[7:0], 8'h80, seed[15:8], seed[7:0]);
    @(posedge sys_clk);
    chk(rx_far_fail, 1);
    rdc(`E3OH_IDX_RX_OPERATOR, seed[15:8]);
    rdc(`E3OH_IDX_RX_CHANNEL, seed[7:0]);
    txr;
    chk(tx_ma_byte[6], 0);
    rxf(seed[7:0], ~seed[7:0], 8'h40, 8'h0, 8'h0);
    @(posedge sys_clk);
    chk(rx_far_err, 1);
    txr;
    chk(tx_ma_byte[6], 1);
    txr;
    chk(tx_ma_byte[6], 0);
    $display("test block error done");
    wb(1'h1, `E3OH_IDX_CTRL, 8'h05);
    seed = lfsr(seed);
    push(seed[7:0]);
    txr;
    chk({tx_nr_byte, tx_gc_byte}, {seed[7:0], chv});
    txr;
    chk(tx_nr_byte, `E3OH_LINK_IDLE);
    wb(1'h1, `E3OH_IDX_CTRL, 8'h06);
    push(seed[15:8]);
    txr;
    chk({tx_nr_byte, tx_gc_byte}, {opv, seed[15:8]});
    $display("test link transmit done");
    stall <= 1'h1;
    for (k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      rxf(8'h0, 8'h0, 8'h0, 8'h0, seed[7:0]);
      if (k < 2)
        exq.push_back(seed[7:0]);
    end
    rdc(`E3OH_IDX_STATUS, 8'h04);
    wb(1'h1, `E3OH_IDX_STATUS, 8'h04);
    rdc(`E3OH_IDX_STATUS, 8'h00);
    stall <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk(exq.size(), 0);
    $display("test link receive done");
    test_done;
  end
endmodule
`default_nettype wire
